// File: rtl/sradc_pkg.sv
// Constants for the serial shift-register address controller
package sradc_pkg;
    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int PHYS_LEN     = 1024;
    localparam int EXTRA_STAGES = 0;
    localparam int LOOP_LEN     = PHYS_LEN + EXTRA_STAGES;
    localparam int EFF_LEN      = LOOP_LEN - 4;
    localparam int DBL_STATES   = LOOP_LEN - EFF_LEN;
    localparam int AW           = 10;
    localparam int DW           = 4;
    localparam int CW           = 11;
    localparam logic [AW-1:0] EFF_LAST  = AW'(EFF_LEN - 1);
    localparam logic [AW-1:0] DBL_FIRST = AW'(EFF_LEN - DBL_STATES);
    localparam logic [CW-1:0] CIRC_LAST = CW'(EFF_LEN - 1);
    // ----------------------------------------------------------------
    // Word codes
    // ----------------------------------------------------------------
    localparam logic [DW-1:0] MARK_LO   = 4'hA;
    localparam logic [DW-1:0] SYNC_CODE = 4'hF;
    localparam logic [AW-1:0] SYNC_ADDR = 10'h000;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS      = 8;
    localparam int MIN_STEP_NS = 500;
    localparam int STEP_CYC    = (MIN_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [5:0] STEP_LAST = 6'(STEP_CYC - 1);
    localparam int HOLD_US     = 1000;
    localparam int HOLD_CYC    = (HOLD_US * 1000) / CLK_NS;
    // ----------------------------------------------------------------
    // Commands and states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SRADC_OP_SEEK = 3'b000,
        SRADC_OP_MARK = 3'b001,
        SRADC_OP_SYNC = 3'b010,
        SRADC_OP_INIT = 3'b011,
        SRADC_OP_SCAN = 3'b100
    } sradc_op_e;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEEK = 3'b001,
        ST_MARK = 3'b010,
        ST_SYNC = 3'b011,
        ST_INIT = 3'b100,
        ST_SCAN = 3'b101
    } sradc_st_e;
endpackage

// File: rtl/sradc_ctrl.sv
// Address controller for a recirculating serial shift-register memory
//
// What this block does
// - The position counter wraps once per full circulation of the stored data.
// - The modulus covers the whole loop, extra recirculation stages included.
// - On a seek the register and counter step together until the counter equals the address.
// - Each step takes the minimum step interval, so a seek lasts at most length times it.
// - With a shortened length the counter wraps at the effective length.
// - For exactly physical minus effective counter states the register gets two shift pulses.
// - A doubled step loads the same item into both positions and reads them as one item.
// - Codes 10 to 15 of the 4-bit word are never data and mark string starts.
// - A marker search circulates until the wanted marker sits at the terminal.
// - A separate marker track bit can flag marker words for wide data.
// - One reserved code lives at a fixed reserved address that holds no data.
// - A resync circulates until the reserved code appears and reloads the counter.
// - An init command writes the reserved code into its reserved location.
// - A content scan compares each word up to the first match during exactly one circulation.
// - While ce is high and req_valid is not held, the register is never left unstepped beyond its hold period.
`timescale 1ns/1ps
`default_nettype none
module sradc_ctrl
    import sradc_pkg::*;
#(
    parameter int HOLD_LIMIT = sradc_pkg::HOLD_CYC
) (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     ce,
    input  wire logic                     req_valid,
    input  wire sradc_pkg::sradc_op_e     req_op,
    input  wire logic [sradc_pkg::AW-1:0] req_addr,
    input  wire logic [sradc_pkg::DW-1:0] req_key,
    input  wire logic                     acc_we,
    input  wire logic [sradc_pkg::DW-1:0] acc_wdata,
    input  wire logic [sradc_pkg::DW-1:0] sr_rdata,
    input  wire logic                     sr_rmark,
    output logic                          sr_shift_q,
    output logic                          sr_load_q,
    output logic [sradc_pkg::DW-1:0]      sr_wdata_q,
    output logic [sradc_pkg::AW-1:0]      cnt_q,
    output logic                          ready_q,
    output logic                          busy_q,
    output logic                          found_q,
    output logic                          miss_q,
    output logic [sradc_pkg::AW-1:0]      found_addr_q
);
    import sradc_pkg::*;

    sradc_st_e       st_q;
    logic [AW-1:0]   tgt_q;
    logic [DW-1:0]   key_q;
    logic            stepping_q;
    logic [5:0]      stp_q;
    logic            dbl_q;
    logic [CW-1:0]   nstep_q;
    logic [16:0]     idle_q;
    logic            step_go;
    logic            step_end;
    logic            step_ld;
    logic [DW-1:0]   step_data;
    logic            dbl_now;
    logic            mark_hit;
    logic            sync_hit;
    logic            circ_done;
    logic            park;

    // ----------------------------------------------------------------
    // Decisions between steps
    // ----------------------------------------------------------------
    assign dbl_now   = (cnt_q >= DBL_FIRST);
    assign mark_hit  = (sr_rdata == key_q) && ((key_q >= MARK_LO) || sr_rmark);
    assign sync_hit  = (st_q == ST_SYNC) && !stepping_q && (sr_rdata == SYNC_CODE);
    assign circ_done = (nstep_q == CIRC_LAST);
    assign step_end  = stepping_q && (stp_q == STEP_LAST);
    // Park one position ahead well before the data would decay
    assign park      = (idle_q >= 17'(HOLD_LIMIT - 2 * STEP_CYC));

    always_comb begin
        step_go   = 1'b0;
        step_ld   = 1'b0;
        step_data = acc_wdata;
        if (!stepping_q) begin
            unique case (st_q)
                ST_IDLE: begin
                    step_go = park || (acc_we && ready_q);
                    step_ld = acc_we && ready_q;
                end
                ST_SEEK: step_go = (cnt_q != tgt_q);
                ST_MARK: step_go = !mark_hit && !circ_done;
                ST_SYNC: step_go = !sync_hit && !circ_done;
                ST_INIT: begin
                    step_go   = 1'b1;
                    step_ld   = (cnt_q == SYNC_ADDR);
                    step_data = SYNC_CODE;
                end
                ST_SCAN: step_go = !circ_done;
                default: step_go = 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Command sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q  <= ST_IDLE;
            tgt_q <= '0;
            key_q <= '0;
        end else if (ce) begin
            if (req_valid && !stepping_q) begin
                tgt_q <= req_addr;
                key_q <= req_key;
                unique case (req_op)
                    SRADC_OP_SEEK: st_q <= ST_SEEK;
                    SRADC_OP_MARK: st_q <= ST_MARK;
                    SRADC_OP_SYNC: st_q <= ST_SYNC;
                    SRADC_OP_INIT: st_q <= ST_INIT;
                    SRADC_OP_SCAN: st_q <= ST_SCAN;
                    default:       st_q <= ST_IDLE;
                endcase
            end else if (!stepping_q && !step_go) begin
                st_q <= ST_IDLE;
            end else if (step_go && step_ld && st_q == ST_INIT) begin
                st_q <= ST_IDLE;
            end
        end
    end

    // ----------------------------------------------------------------
    // Step engine: one data interval, one or two shift pulses
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stepping_q <= 1'b0;
            stp_q      <= '0;
            dbl_q      <= 1'b0;
            sr_shift_q <= 1'b0;
            sr_load_q  <= 1'b0;
            sr_wdata_q <= '0;
        end else if (ce) begin
            if (step_go && !req_valid) begin
                stepping_q <= 1'b1;
                stp_q      <= '0;
                dbl_q      <= dbl_now;
                sr_shift_q <= 1'b1;
                sr_load_q  <= step_ld;
                sr_wdata_q <= step_data;
            end else if (stepping_q) begin
                stp_q      <= stp_q + 6'h01;
                // Second pulse reuses the held load data
                sr_shift_q <= (stp_q == 6'h00) && dbl_q;
                if (stp_q == 6'h01) begin
                    sr_load_q <= 1'b0;
                end
                if (step_end) begin
                    stepping_q <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Position counter
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (ce) begin
            if (sync_hit) begin
                cnt_q <= SYNC_ADDR;
            end else if (step_end) begin
                cnt_q <= (cnt_q == EFF_LAST) ? '0 : cnt_q + 10'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Circulation and hold timers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            nstep_q <= '0;
            idle_q  <= '0;
        end else if (ce) begin
            if (req_valid && !stepping_q) begin
                nstep_q <= '0;
            end else if (step_end) begin
                nstep_q <= nstep_q + 11'h001;
            end
            idle_q <= sr_shift_q ? '0 : idle_q + 17'h00001;
        end
    end

    // ----------------------------------------------------------------
    // Status
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ready_q      <= 1'b0;
            busy_q       <= 1'b0;
            found_q      <= 1'b0;
            miss_q       <= 1'b0;
            found_addr_q <= '0;
        end else if (ce) begin
            busy_q <= (st_q != ST_IDLE) || stepping_q || (req_valid && !stepping_q);
            if (req_valid && !stepping_q) begin
                ready_q <= 1'b0;
                found_q <= 1'b0;
                miss_q  <= 1'b0;
            end else if (step_go) begin
                ready_q <= 1'b0;
            end else if (!stepping_q) begin
                unique case (st_q)
                    ST_SEEK: ready_q <= 1'b1;
                    ST_MARK: begin
                        ready_q      <= mark_hit;
                        found_q      <= mark_hit;
                        miss_q       <= !mark_hit;
                        found_addr_q <= cnt_q;
                    end
                    ST_SYNC: miss_q <= !sync_hit;
                    default: ready_q <= ready_q;
                endcase
            end
            if (st_q == ST_SCAN && !stepping_q && !found_q && sr_rdata == key_q) begin
                found_q      <= 1'b1;
                found_addr_q <= cnt_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence step_start_s;
        !stepping_q ##1 stepping_q && stp_q == 6'h00;
    endsequence
    sequence two_pulses_s;
        sr_shift_q ##1 sr_shift_q ##1 !sr_shift_q;
    endsequence

    cnt_wrap_a: assert property (@(posedge mclk) disable iff (rst || !ce)
        step_end && cnt_q == EFF_LAST && !sync_hit |=> cnt_q == '0)
        else $error("counter did not wrap at effective length");
    cnt_range_a: assert property (@(posedge mclk) disable iff (rst)
        cnt_q <= EFF_LAST)
        else $error("counter beyond effective length");
    double_pulse_a: assert property (@(posedge mclk) disable iff (rst || !ce)
        step_start_s ##0 dbl_q |-> two_pulses_s)
        else $error("doubled step lacks two shift pulses");
    single_pulse_a: assert property (@(posedge mclk) disable iff (rst || !ce)
        step_start_s ##0 !dbl_q |-> sr_shift_q ##1 !sr_shift_q)
        else $error("single step pulsed twice");
    load_both_a: assert property (@(posedge mclk) disable iff (rst || !ce)
        step_start_s ##0 dbl_q && sr_load_q |=> sr_load_q && $stable(sr_wdata_q))
        else $error("doubled load not held for second pulse");
    seek_stop_a: assert property (@(posedge mclk) disable iff (rst || !ce)
        st_q == ST_SEEK && !stepping_q && !req_valid && cnt_q == tgt_q |=> ready_q && !sr_shift_q)
        else $error("seek did not stop at target");
    step_len_a: assert property (@(posedge mclk) disable iff (rst || !ce)
        stepping_q && stp_q != STEP_LAST |=> stepping_q)
        else $error("step shorter than minimum interval");
    sync_load_a: assert property (@(posedge mclk) disable iff (rst || !ce)
        sync_hit && !req_valid |=> cnt_q == SYNC_ADDR && !stepping_q)
        else $error("counter not reloaded on sync code");
    hold_lim_a: assert property (@(posedge mclk) disable iff (rst)
        idle_q < 17'(HOLD_LIMIT))
        else $error("register left unstepped too long");
    ready_still_a: assert property (@(posedge mclk) disable iff (rst)
        ready_q |-> !stepping_q)
        else $error("shifting while location ready");
endmodule
`default_nettype wire

// File: tb/sradc_sr_model.sv
// Behavioural recirculating shift-register array at the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module sradc_sr_model
    import sradc_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     sr_shift,
    input  wire logic                     sr_load,
    input  wire logic [sradc_pkg::DW-1:0] sr_wdata,
    output logic [sradc_pkg::DW-1:0]      sr_rdata,
    output logic                          sr_rmark
);
    logic [DW-1:0] mem [PHYS_LEN];
    logic          mtrk [PHYS_LEN];
    int            head;

    initial begin
        head = 0;
        for (int i = 0; i < PHYS_LEN; i++) begin
            mem[i] = 4'h0;
            mtrk[i] = 1'b0;
        end
    end

    // One physical stage per pulse; a doubled step simply gets two pulses
    always @(posedge mclk) begin
        if (sr_shift) begin
            if (sr_load) begin
                mem[head] <= sr_wdata;
            end
            head <= (head + 1) % PHYS_LEN;
        end
    end

    // Track bits are placed by the bench and never rewritten by loads
    assign sr_rdata = mem[head];
    assign sr_rmark = mtrk[head];
endmodule
`default_nettype wire

// File: tb/test_sradc_ctrl.sv
// Self-checking bench for the shift-register address controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
    $display("FAIL t=%0t got %0h exp %0h", $time, (a), (b)); end end
module test_sradc_ctrl;
    import sradc_pkg::*;
    // Short hold limit so the park step shows up within the run
    localparam int HOLD = 2000;
    logic            mclk, rst, ce, req_valid, acc_we, sr_rmark;
    logic            sr_shift_q, sr_load_q, ready_q, busy_q, found_q, miss_q;
    sradc_op_e       req_op;
    logic [AW-1:0]   req_addr, cnt_q, found_addr_q;
    logic [DW-1:0]   req_key, acc_wdata, sr_rdata, sr_wdata_q;
    int              n_errors, samples_checked, n;
    logic [AW-1:0]   cnt_before;
    logic [25:0]     outs_all;

    sradc_ctrl #(.HOLD_LIMIT(HOLD)) sradc_ctrl_inst (
        .mclk(mclk), .rst(rst), .ce(ce), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_key(req_key), .acc_we(acc_we), .acc_wdata(acc_wdata),
        .sr_rdata(sr_rdata), .sr_rmark(sr_rmark), .sr_shift_q(sr_shift_q),
        .sr_load_q(sr_load_q), .sr_wdata_q(sr_wdata_q), .cnt_q(cnt_q), .ready_q(ready_q),
        .busy_q(busy_q), .found_q(found_q), .miss_q(miss_q), .found_addr_q(found_addr_q));

    sradc_sr_model sradc_sr_model_inst (
        .mclk(mclk), .sr_shift(sr_shift_q), .sr_load(sr_load_q), .sr_wdata(sr_wdata_q),
        .sr_rdata(sr_rdata), .sr_rmark(sr_rmark));

    assign outs_all = {cnt_q, found_addr_q, ready_q, busy_q,
                       found_q, miss_q, sr_shift_q, sr_load_q};

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task final_report;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Shared drivers
    // ----------------------------------------------------------------
    task issue(input sradc_op_e op, input logic [AW-1:0] a, input logic [DW-1:0] k);
        @(negedge mclk);
        req_op = op;
        req_addr = a;
        req_key = k;
        req_valid = 1'b1;
        @(negedge mclk);
        req_valid = 1'b0;
    endtask

    task wait_idle(input int lim);
        int i;
        repeat (3) @(negedge mclk);
        for (i = 0; i < lim && busy_q !== 1'b0; i++) @(negedge mclk);
        repeat (2) @(negedge mclk);
        `CHK(busy_q, 1'b0)
    endtask

    task write_word(input logic [DW-1:0] d);
        @(negedge mclk);
        acc_wdata = d;
        acc_we = 1'b1;
        @(negedge mclk);
        acc_we = 1'b0;
        wait_idle(300);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_seek_near;
        issue(SRADC_OP_SEEK, 10'h003, 4'h0);
        n = 0;
        while (ready_q !== 1'b1 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        `CHK(n >= 63 * 3 - 2 && n <= 63 * 3 + 4, 1'b1)
        `CHK(cnt_q, 10'h003)
        repeat (5) @(negedge mclk);
        `CHK(sradc_sr_model_inst.head, 3)
        `CHK(ready_q, 1'b1)
    endtask

    task t_write;
        write_word(4'h7);
        `CHK(sradc_sr_model_inst.mem[3], 4'h7)
        `CHK(cnt_q, 10'h004)
        `CHK(ready_q, 1'b0)
    endtask

    // Crossing counts 1016 and 1017 costs two physical stages each
    task t_seek_doubled;
        issue(SRADC_OP_SEEK, 10'h3FA, 4'h0);
        wait_idle(70000);
        `CHK(cnt_q, 10'h3FA)
        `CHK(sradc_sr_model_inst.head, 1020)
        // A write at a doubled count lands in two physical stages
        write_word(4'h5);
        `CHK(sradc_sr_model_inst.mem[1020], 4'h5)
        `CHK(sradc_sr_model_inst.mem[1021], 4'h5)
        `CHK(cnt_q, 10'h3FB)
    endtask

    task t_init;
        issue(SRADC_OP_INIT, 10'h000, 4'h0);
        wait_idle(1000);
        `CHK(sradc_sr_model_inst.mem[0], SYNC_CODE)
        `CHK(sradc_sr_model_inst.head, 1)
        `CHK(cnt_q, 10'h001)
    endtask

    // Stage 6 holds a plain data 2, stage 8 a 2 flagged on the track
    task t_mark;
        issue(SRADC_OP_MARK, 10'h000, 4'h2);
        wait_idle(1000);
        `CHK(found_q, 1'b1)
        `CHK(found_addr_q, 10'h008)
        issue(SRADC_OP_MARK, 10'h000, 4'hB);
        wait_idle(2000);
        `CHK(found_q, 1'b1)
        `CHK(cnt_q, 10'h00A)
        `CHK(found_addr_q, 10'h00A)
        `CHK(miss_q, 1'b0)
        `CHK(ready_q, 1'b1)
    endtask

    // The code at stage 20 stands for a counter that lost step
    task t_sync;
        issue(SRADC_OP_SYNC, 10'h000, 4'h0);
        wait_idle(2000);
        `CHK(cnt_q, SYNC_ADDR)
        `CHK(sradc_sr_model_inst.head, 20)
    endtask

    task t_park;
        cnt_before = cnt_q;
        n = 0;
        while (sr_shift_q !== 1'b1 && n < HOLD) begin
            @(negedge mclk);
            n++;
        end
        `CHK(n < HOLD, 1'b1)
        wait_idle(200);
        `CHK(cnt_q, cnt_before + 10'h001)
    endtask

    // A full scan would outlast the run, so the hit is taken early
    // and the scan is cut by a frozen enable and then a reset
    task t_scan;
        issue(SRADC_OP_SCAN, 10'h000, 4'h9);
        n = 0;
        while (found_q !== 1'b1 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        `CHK(found_q, 1'b1)
        `CHK(found_addr_q, 10'h003)
        `CHK(busy_q, 1'b1)
        repeat (5) @(negedge mclk);
        ce = 1'b0;
        cnt_before = cnt_q;
        n = sradc_sr_model_inst.head;
        repeat (100) @(negedge mclk);
        `CHK(cnt_q, cnt_before)
        `CHK(sradc_sr_model_inst.head, n)
        ce = 1'b1;
        rst = 1'b1;
        @(negedge mclk);
        `CHK(outs_all, 26'h0000000)
        rst = 1'b0;
        repeat (2) begin
            @(negedge mclk);
            `CHK(outs_all, 26'h0000000)
        end
    endtask

    initial begin
        n_errors = 0;
        samples_checked = 0;
        rst = 1'b1;
        ce = 1'b1;
        req_valid = 1'b0;
        req_op = SRADC_OP_SEEK;
        req_addr = 10'h000;
        req_key = 4'h0;
        acc_we = 1'b0;
        acc_wdata = 4'h0;
        repeat (10) @(negedge mclk);
        `CHK({cnt_q, ready_q, busy_q, sr_shift_q}, 13'h0000)
        sradc_sr_model_inst.mem[5] = 4'hC;
        sradc_sr_model_inst.mem[10] = 4'hB;
        sradc_sr_model_inst.mem[20] = SYNC_CODE;
        sradc_sr_model_inst.mem[6] = 4'h2;
        sradc_sr_model_inst.mem[8] = 4'h2;
        sradc_sr_model_inst.mtrk[8] = 1'b1;
        sradc_sr_model_inst.mem[23] = 4'h9;
        rst = 1'b0;
        t_seek_near();
        t_write();
        t_seek_doubled();
        t_init();
        t_mark();
        t_sync();
        t_park();
        t_scan();
        final_report();
    end

    initial begin
        #(8 * 90000);
        n_errors++;
        final_report();
    end
endmodule
`default_nettype wire
